//--- test_wdtint_top.sv
`timescale 1ns/1ps
module test_wdtint_top;
    import wdtint_pkg::*;
    // ****************************************************
    // Stimulus and observed signals
    // ****************************************************
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] bus_addr = 8'h00;
    logic [31:0] bus_wdata = 32'h0000_0000;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [31:0] bus_rdata;
    logic core_debug_acknowledge = 1'b0;
    logic wdt_irq;
    logic wdt_sys_reset;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;
    int seed = 58943;
    int n;
    int psc;
    logic [31:0] rv;
    logic [31:0] exp_q[$];
    logic rd_seen = 1'b0;

    wdtint_top i_wdtint_top (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .bus_addr(bus_addr),
        .bus_wdata(bus_wdata),
        .bus_wr(bus_wr),
        .bus_rd(bus_rd),
        .bus_rdata(bus_rdata),
        .core_debug_acknowledge(core_debug_acknowledge),
        .wdt_irq(wdt_irq),
        .wdt_sys_reset(wdt_sys_reset)
    );

    // 10 MHz clock
    always #50 sys_clk = ~sys_clk;

    // Read data model: queued word after a read, zero otherwise
    always @(posedge sys_clk) begin
        rd_seen <= bus_rd;
    end

    always @(negedge sys_clk) begin
        if (rst_b === 1'b1) begin
            if (rd_seen && exp_q.size() > 0) begin
                check(bus_rdata, exp_q.pop_front());
            end else begin
                check(bus_rdata, 32'h0000_0000);
            end
        end
    end

    // Hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            end_of_test();
        end
    end

    // ****************************************************
    // Shared tasks
    // ****************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask

    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge sys_clk);
        bus_wr <= 1'b0;
    endtask

    // Read, data taken in the cycle after the strobe
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        exp_q.push_back(exp);
        @(posedge sys_clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge sys_clk);
        bus_rd <= 1'b0;
        @(negedge sys_clk);
    endtask

    // Edges until irq (sel 0) or reset (sel 1) goes high
    task automatic wait_rise(input bit sel, output int k);
        k = 0;
        do begin
            @(posedge sys_clk);
            #1;
            k++;
        end while (((sel ? wdt_sys_reset : wdt_irq) !== 1'b1) && k < 2000);
    endtask

    // Stop, clear the count, then start with the given control
    task automatic arm(input logic [31:0] ctrl);
        wr(WDTINT_CTRL_OFS, 32'h0000_0000);
        wr(WDTINT_COUNT_OFS, 32'h0000_0000);
        wr(WDTINT_CTRL_OFS, ctrl);
    endtask

    task automatic end_of_test;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ****************************************************
    // Main sequence
    // ****************************************************
    initial begin
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        // Reset values and the unmapped hole
        rchk(WDTINT_CTRL_OFS, 32'h0000_8021);
        rchk(WDTINT_RELOAD_OFS, 32'h0000_8000);
        rchk(WDTINT_COUNT_OFS, 32'h0000_8000);
        rchk(WDTINT_STAT_OFS, 32'h0000_0000);
        rchk(WDTINT_MASK_OFS, 32'h0000_0003);
        wr(8'h14, 32'hFFFF_FFFF);
        rchk(8'h14, 32'h0000_0000);
        wr(WDTINT_CTRL_OFS, 32'h0000_FFFF);
        rchk(WDTINT_CTRL_OFS, 32'h0000_FF3D);
        $display("test registers done");
        // Count writes, no reload on enable, decrement and hold
        wr(WDTINT_CTRL_OFS, 32'h0000_0000);
        rv = $random(seed) & 32'h0000_FFFF;
        wr(WDTINT_COUNT_OFS, rv);
        rchk(WDTINT_COUNT_OFS, rv);
        wr(WDTINT_RELOAD_OFS, 32'h0000_1000);
        wr(WDTINT_COUNT_OFS, 32'h0000_0030);
        wr(WDTINT_CTRL_OFS, 32'h0000_0020);
        rchk(WDTINT_COUNT_OFS, 32'h0000_0030);
        repeat (22) @(posedge sys_clk);
        rchk(WDTINT_COUNT_OFS, 32'h0000_002F);
        wr(WDTINT_CTRL_OFS, 32'h0000_0000);
        repeat (100) @(posedge sys_clk);
        rchk(WDTINT_COUNT_OFS, 32'h0000_002F);
        $display("test counting done");
        // Interval mode for every division factor
        for (int s = 0; s < 4; s++) begin
            psc = $random(seed) & 7;
            arm((psc << 8) | (s << 3) | 32'h0000_0024);
            wait_rise(1'b0, n);
            check(n, (psc + 1) * (16 << s) + 1);
            check(wdt_sys_reset, 1'b0);
            rchk(WDTINT_COUNT_OFS, 32'h0000_1000);
            rchk(WDTINT_STAT_OFS, 32'h0000_0001);
            wr(WDTINT_STAT_OFS, 32'h0000_0001);
            #1;
            check(wdt_irq, 1'b0);
        end
        $display("test interval done");
        // Masked time-out shows in status only
        wr(WDTINT_MASK_OFS, 32'h0000_0000);
        arm(32'h0000_0024);
        repeat (30) @(posedge sys_clk);
        check(wdt_irq, 1'b0);
        rchk(WDTINT_STAT_OFS, 32'h0000_0001);
        wr(WDTINT_MASK_OFS, 32'h0000_0003);
        #1;
        check(wdt_irq, 1'b1);
        wr(WDTINT_STAT_OFS, 32'h0000_0001);
        #1;
        check(wdt_irq, 1'b0);
        $display("test mask done");
        // Reset pulse length, interrupt off
        arm(32'h0000_0021);
        wait_rise(1'b1, n);
        check(n, 17);
        n = 0;
        while (wdt_sys_reset === 1'b1 && n < 300) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        check(n, 128);
        rchk(WDTINT_STAT_OFS, 32'h0000_0002);
        wr(WDTINT_STAT_OFS, 32'h0000_0003);
        $display("test reset pulse done");
        // Debug acknowledge stops the timer and blocks the reset
        @(posedge sys_clk);
        core_debug_acknowledge <= 1'b1;
        arm(32'h0000_0021);
        repeat (200) @(posedge sys_clk);
        check(wdt_sys_reset, 1'b0);
        rchk(WDTINT_COUNT_OFS, 32'h0000_0000);
        @(posedge sys_clk);
        core_debug_acknowledge <= 1'b0;
        wait_rise(1'b1, n);
        check(n, 17);
        $display("test debug done");
        end_of_test();
    end
endmodule

//--- wdtint_pkg.sv
package wdtint_pkg;

    // ********************************************************
    // Register map, byte addresses
    // ********************************************************
    localparam logic [7:0] WDTINT_CTRL_OFS = 8'h00;
    localparam logic [7:0] WDTINT_RELOAD_OFS = 8'h04;
    localparam logic [7:0] WDTINT_COUNT_OFS = 8'h08;
    localparam logic [7:0] WDTINT_STAT_OFS = 8'h0C;
    localparam logic [7:0] WDTINT_MASK_OFS = 8'h10;

    // ********************************************************
    // Control field positions
    // ********************************************************
    localparam int WDTINT_CTRL_RST_EN_BIT = 0;
    localparam int WDTINT_CTRL_INT_EN_BIT = 2;
    localparam int WDTINT_CTRL_DIV_LSB = 3;
    localparam int WDTINT_CTRL_EN_BIT = 5;
    localparam int WDTINT_CTRL_PSC_LSB = 8;

    // Status and mask bit positions
    localparam int WDTINT_EV_TIMEOUT_BIT = 0;
    localparam int WDTINT_EV_RESET_BIT = 1;

    // ********************************************************
    // Reset values and write masks
    // ********************************************************
    localparam logic [15:0] WDTINT_CTRL_RST = 16'h8021;
    localparam logic [15:0] WDTINT_CTRL_WMASK = 16'hFF3D;
    localparam logic [15:0] WDTINT_RELOAD_RST = 16'h8000;
    localparam logic [15:0] WDTINT_COUNT_RST = 16'h8000;
    localparam logic [1:0] WDTINT_STAT_RST = 2'h0;
    localparam logic [1:0] WDTINT_MASK_RST = 2'h3;

    // ********************************************************
    // Timing counts: reset pulse in sys_clk cycles, divider base in prescaler steps
    // ********************************************************
    localparam logic [7:0] WDTINT_RST_PULSE_CYCLES = 8'h80;
    localparam logic [7:0] WDTINT_DIV_BASE = 8'h10;

    // Reset pulse stretcher states
    typedef enum logic {
        WDTINT_PULSE_IDLE = 1'b0,
        WDTINT_PULSE_ACTIVE = 1'b1
    } wdtint_pulse_state_t;

    // Division factor 16, 32, 64 or 128 from the select field
    function automatic logic [7:0] wdtint_div_factor(input logic [1:0] sel);
        wdtint_div_factor = WDTINT_DIV_BASE << sel;
    endfunction

endpackage

//--- wdtint_rst_pulse.sv
`timescale 1ns/1ps
module wdtint_rst_pulse (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic start,
    output logic pulse
);
    import wdtint_pkg::*;

    typedef struct packed {
        wdtint_pulse_state_t state;
        logic [6:0] cnt;
        logic pulse;
    } wdtint_pulse_reg_t;

    wdtint_pulse_reg_t s_r;
    wdtint_pulse_reg_t s_nxt;

    // Stretch one start into a fixed reset pulse
    always_comb begin
        s_nxt = s_r;
        unique case (s_r.state)
            WDTINT_PULSE_IDLE: begin
                if (start) begin
                    s_nxt.state = WDTINT_PULSE_ACTIVE;
                    s_nxt.cnt = 7'h00;
                end
            end
            WDTINT_PULSE_ACTIVE: begin
                s_nxt.cnt = s_r.cnt + 7'h01;
                if (s_r.cnt == 7'(WDTINT_RST_PULSE_CYCLES - 8'h01)) begin
                    s_nxt.state = WDTINT_PULSE_IDLE;
                end
            end
        endcase
        s_nxt.pulse = (s_nxt.state == WDTINT_PULSE_ACTIVE);
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            s_r <= '{WDTINT_PULSE_IDLE, 7'h00, 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pulse = s_r.pulse;

    property p_pulse_len;
        @(posedge sys_clk) disable iff (!rst_b)
        $fell(s_r.pulse) |-> $past(s_r.cnt) == 7'h7F;
    endproperty
    a_pulse_len: assert property (p_pulse_len)
        else $error("reset pulse not 128 cycles");

endmodule

//--- wdtint_tick_gen.sv
`timescale 1ns/1ps
module wdtint_tick_gen (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic run,
    input wire logic [7:0] psc,
    input wire logic [1:0] div_sel,
    output logic tick
);
    import wdtint_pkg::*;

    typedef struct packed {
        logic [7:0] psc_cnt;
        logic [6:0] div_cnt;
        logic tick;
    } wdtint_tick_state_t;

    wdtint_tick_state_t s_r;
    wdtint_tick_state_t s_nxt;
    logic [6:0] div_last;

    // Prescaler then divider, both cleared while stopped
    always_comb begin
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        div_last = 7'(wdtint_div_factor(div_sel) - 8'h01);
        if (!run) begin
            s_nxt = '0;
        end else if (s_r.psc_cnt >= psc) begin
            s_nxt.psc_cnt = 8'h00;
            if (s_r.div_cnt >= div_last) begin
                s_nxt.div_cnt = 7'h00;
                s_nxt.tick = 1'b1;
            end else begin
                s_nxt.div_cnt = s_r.div_cnt + 7'h01;
            end
        end else begin
            s_nxt.psc_cnt = s_r.psc_cnt + 8'h01;
        end
    end

    // Only sys_clk drives the chain
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tick = s_r.tick;

    // ********************************************************
    // Checks
    // ********************************************************
    logic [15:0] gap_r;
    logic seen_r;

    // Cycles since last tick under steady settings
    always_ff @(posedge sys_clk) begin
        if (!rst_b || !run || $changed(psc) || $changed(div_sel)) begin
            gap_r <= 16'h0000;
            seen_r <= 1'b0;
        end else if (s_r.tick) begin
            gap_r <= 16'h0001;
            seen_r <= 1'b1;
        end else begin
            gap_r <= gap_r + 16'h0001;
        end
    end

    property p_tick_period;
        @(posedge sys_clk) disable iff (!rst_b)
        (s_r.tick && seen_r && run && $stable(psc) && $stable(div_sel))
            |-> gap_r == 16'((psc + 16'h0001) * wdtint_div_factor(div_sel));
    endproperty
    a_tick_period: assert property (p_tick_period)
        else $error("tick period differs from prescale times factor");

    property p_no_tick_stopped;
        @(posedge sys_clk) disable iff (!rst_b)
        !run |=> !s_r.tick;
    endproperty
    a_no_tick_stopped: assert property (p_no_tick_stopped)
        else $error("tick while stopped");

endmodule

//--- wdtint_top.sv
// What this block does
// - 16-bit down counter, interval interrupt on expiry
// - Time-out with reset enabled: 128-cycle reset
// - Counting chain clocked only by sys_clk
// - 8-bit prescaler divides by value plus one
// - Second divider by 16, 32, 64, 128
// - Tick equals (prescale+1) times factor cycles
// - Enabling keeps the current count, no reload
// - Debug acknowledge stops the timer
// - Debug acknowledge blocks the start of a reset pulse, not one under way
// - Time-out without a count write reloads count from reload register
// - Control bit 5 enables the timer
// - Control bit 2 enables time-out interrupt
// - Control bit 0 enables time-out reset
`timescale 1ns/1ps
module wdtint_top (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [7:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [31:0] bus_rdata,
    input wire logic core_debug_acknowledge,
    output logic wdt_irq,
    output logic wdt_sys_reset
);
    import wdtint_pkg::*;

    // ********************************************************
    // State
    // ********************************************************
    typedef struct packed {
        logic [15:0] ctrl;
        logic [15:0] reload;
        logic [15:0] count;
        logic [1:0] stat;
        logic [1:0] mask;
        logic [31:0] rdata;
    } wdtint_top_state_t;

    wdtint_top_state_t s_r;
    wdtint_top_state_t s_nxt;

    logic tick;
    logic run;
    logic timeout;
    logic rst_start;
    logic wr_count;
    logic [1:0] ev_set;
    logic [1:0] ev_clr;

    // Timer runs when enabled and core not in debug
    assign run = s_r.ctrl[WDTINT_CTRL_EN_BIT]
        && !core_debug_acknowledge;
    assign timeout = run && tick && (s_r.count == 16'h0000);
    assign rst_start = timeout
        && s_r.ctrl[WDTINT_CTRL_RST_EN_BIT]
        && !core_debug_acknowledge;
    assign wr_count = bus_wr && (bus_addr == WDTINT_COUNT_OFS);

    // ********************************************************
    // Tick generation and reset stretcher
    // ********************************************************
    wdtint_tick_gen u_tick (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .run(run),
        .psc(s_r.ctrl[WDTINT_CTRL_PSC_LSB +: 8]),
        .div_sel(s_r.ctrl[WDTINT_CTRL_DIV_LSB +: 2]),
        .tick(tick)
    );

    wdtint_rst_pulse u_pulse (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .start(rst_start),
        .pulse(wdt_sys_reset)
    );

    // ********************************************************
    // Next state: registers, counter, events, read data
    // ********************************************************
    always_comb begin
        s_nxt = s_r;
        ev_set = 2'h0;
        ev_clr = 2'h0;
        ev_set[WDTINT_EV_TIMEOUT_BIT] = timeout
            && s_r.ctrl[WDTINT_CTRL_INT_EN_BIT];
        ev_set[WDTINT_EV_RESET_BIT] = rst_start;

        // Counter: write wins, else tick decrements or reloads
        if (wr_count) begin
            s_nxt.count = bus_wdata[15:0];
        end else if (timeout) begin
            s_nxt.count = s_r.reload;
        end else if (run && tick) begin
            s_nxt.count = s_r.count - 16'h0001;
        end

        // Register writes; enable alone never loads count
        if (bus_wr) begin
            unique case (bus_addr)
                WDTINT_CTRL_OFS:
                    s_nxt.ctrl = bus_wdata[15:0] & WDTINT_CTRL_WMASK;
                WDTINT_RELOAD_OFS:
                    s_nxt.reload = bus_wdata[15:0];
                WDTINT_STAT_OFS:
                    ev_clr = bus_wdata[1:0];
                WDTINT_MASK_OFS:
                    s_nxt.mask = bus_wdata[1:0];
                default: ;
            endcase
        end

        // Sticky status, set beats write-one clear
        s_nxt.stat = (s_r.stat & ~ev_clr) | ev_set;

        // Read data stands one cycle after the strobe
        s_nxt.rdata = 32'h0000_0000;
        if (bus_rd) begin
            unique case (bus_addr)
                WDTINT_CTRL_OFS:
                    s_nxt.rdata[15:0] = s_r.ctrl;
                WDTINT_RELOAD_OFS:
                    s_nxt.rdata[15:0] = s_r.reload;
                WDTINT_COUNT_OFS:
                    s_nxt.rdata[15:0] = s_r.count;
                WDTINT_STAT_OFS:
                    s_nxt.rdata[1:0] = s_r.stat;
                WDTINT_MASK_OFS:
                    s_nxt.rdata[1:0] = s_r.mask;
                default: ;
            endcase
        end
    end

    // State register with documented reset values
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            s_r.ctrl <= WDTINT_CTRL_RST;
            s_r.reload <= WDTINT_RELOAD_RST;
            s_r.count <= WDTINT_COUNT_RST;
            s_r.stat <= WDTINT_STAT_RST;
            s_r.mask <= WDTINT_MASK_RST;
            s_r.rdata <= 32'h0000_0000;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs
    assign bus_rdata = s_r.rdata;
    assign wdt_irq = |(s_r.stat & s_r.mask);

    // ********************************************************
    // Checks
    // ********************************************************
    property p_hold_disabled;
        @(posedge sys_clk) disable iff (!rst_b)
        (!s_r.ctrl[WDTINT_CTRL_EN_BIT] && !wr_count) |=> $stable(s_r.count);
    endproperty
    a_hold_disabled: assert property (p_hold_disabled)
        else $error("count moved while disabled");

    property p_debug_freeze;
        @(posedge sys_clk) disable iff (!rst_b)
        (core_debug_acknowledge && !wr_count) |=> $stable(s_r.count);
    endproperty
    a_debug_freeze: assert property (p_debug_freeze)
        else $error("count moved during debug");

    property p_decrement;
        @(posedge sys_clk) disable iff (!rst_b)
        (run && tick && s_r.count != 16'h0000 && !wr_count)
            |=> s_r.count == $past(s_r.count) - 16'h0001;
    endproperty
    a_decrement: assert property (p_decrement)
        else $error("count did not decrement on tick");

    property p_reload;
        @(posedge sys_clk) disable iff (!rst_b)
        (timeout && !wr_count) |=> s_r.count == $past(s_r.reload);
    endproperty
    a_reload: assert property (p_reload)
        else $error("no reload at time-out");

    property p_count_write;
        @(posedge sys_clk) disable iff (!rst_b)
        wr_count |=> s_r.count == $past(bus_wdata[15:0]);
    endproperty
    a_count_write: assert property (p_count_write)
        else $error("count write not taken");

    property p_enable_no_load;
        @(posedge sys_clk) disable iff (!rst_b)
        $rose(s_r.ctrl[WDTINT_CTRL_EN_BIT]) && !wr_count
            |=> $stable(s_r.count);
    endproperty
    a_enable_no_load: assert property (p_enable_no_load)
        else $error("enable changed the count");

    property p_reset_fires;
        @(posedge sys_clk) disable iff (!rst_b)
        (timeout && s_r.ctrl[WDTINT_CTRL_RST_EN_BIT]
            && !core_debug_acknowledge && !wdt_sys_reset) |=> wdt_sys_reset;
    endproperty
    a_reset_fires: assert property (p_reset_fires)
        else $error("reset not raised at time-out");

    property p_reset_cause;
        @(posedge sys_clk) disable iff (!rst_b)
        $rose(wdt_sys_reset) |-> $past(s_r.ctrl[WDTINT_CTRL_RST_EN_BIT])
            && !$past(core_debug_acknowledge) && $past(timeout);
    endproperty
    a_reset_cause: assert property (p_reset_cause)
        else $error("reset raised without enabled time-out");

    property p_debug_no_reset;
        @(posedge sys_clk) disable iff (!rst_b)
        core_debug_acknowledge && !wdt_sys_reset |=> !wdt_sys_reset;
    endproperty
    a_debug_no_reset: assert property (p_debug_no_reset)
        else $error("reset raised during debug");

    property p_int_cause;
        @(posedge sys_clk) disable iff (!rst_b)
        $rose(s_r.stat[WDTINT_EV_TIMEOUT_BIT])
            |-> $past(s_r.ctrl[WDTINT_CTRL_INT_EN_BIT]) && $past(timeout);
    endproperty
    a_int_cause: assert property (p_int_cause)
        else $error("interrupt status set without cause");

    property p_set_wins;
        @(posedge sys_clk) disable iff (!rst_b)
        ev_set[WDTINT_EV_TIMEOUT_BIT] |=> s_r.stat[WDTINT_EV_TIMEOUT_BIT];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("time-out event lost");

    // Reset cause is recorded in status
    property p_stat_reset;
        @(posedge sys_clk) disable iff (!rst_b)
        rst_start |=> s_r.stat[WDTINT_EV_RESET_BIT];
    endproperty
    a_stat_reset: assert property (p_stat_reset)
        else $error("reset event not recorded");

    // Writing a one clears the time-out flag when no new event
    property p_stat_clear;
        @(posedge sys_clk) disable iff (!rst_b)
        (bus_wr && bus_addr == WDTINT_STAT_OFS
            && bus_wdata[WDTINT_EV_TIMEOUT_BIT]
            && !ev_set[WDTINT_EV_TIMEOUT_BIT])
            |=> !s_r.stat[WDTINT_EV_TIMEOUT_BIT];
    endproperty
    a_stat_clear: assert property (p_stat_clear)
        else $error("time-out status not cleared by write of one");

    // Time-out with interrupt off leaves the flag clear
    property p_int_off;
        @(posedge sys_clk) disable iff (!rst_b)
        (timeout && !s_r.ctrl[WDTINT_CTRL_INT_EN_BIT]
            && !s_r.stat[WDTINT_EV_TIMEOUT_BIT])
            |=> !s_r.stat[WDTINT_EV_TIMEOUT_BIT];
    endproperty
    a_int_off: assert property (p_int_off)
        else $error("interrupt status set while disabled");

    // Time-out with reset function off raises no reset
    property p_reset_off;
        @(posedge sys_clk) disable iff (!rst_b)
        (timeout && !s_r.ctrl[WDTINT_CTRL_RST_EN_BIT] && !wdt_sys_reset)
            |=> !wdt_sys_reset;
    endproperty
    a_reset_off: assert property (p_reset_off)
        else $error("reset raised while reset function off");

    // Enable bit follows the written value
    property p_ctrl_enable_write;
        @(posedge sys_clk) disable iff (!rst_b)
        (bus_wr && bus_addr == WDTINT_CTRL_OFS)
            |=> s_r.ctrl[WDTINT_CTRL_EN_BIT]
                == $past(bus_wdata[WDTINT_CTRL_EN_BIT]);
    endproperty
    a_ctrl_enable_write: assert property (p_ctrl_enable_write)
        else $error("enable bit write not taken");

    // Reload value write lands next cycle
    property p_reload_write;
        @(posedge sys_clk) disable iff (!rst_b)
        (bus_wr && bus_addr == WDTINT_RELOAD_OFS)
            |=> s_r.reload == $past(bus_wdata[15:0]);
    endproperty
    a_reload_write: assert property (p_reload_write)
        else $error("reload write not taken");

    // Mask write lands next cycle
    property p_mask_write;
        @(posedge sys_clk) disable iff (!rst_b)
        (bus_wr && bus_addr == WDTINT_MASK_OFS)
            |=> s_r.mask == $past(bus_wdata[1:0]);
    endproperty
    a_mask_write: assert property (p_mask_write)
        else $error("mask write not taken");

    // Count read returns the counter, upper half zero
    property p_count_read;
        @(posedge sys_clk) disable iff (!rst_b)
        (bus_rd && bus_addr == WDTINT_COUNT_OFS)
            |=> bus_rdata == {16'h0000, $past(s_r.count)};
    endproperty
    a_count_read: assert property (p_count_read)
        else $error("count read does not match counter");

    c_timeout: cover property (@(posedge sys_clk) disable iff (!rst_b)
        timeout);
    c_reset: cover property (@(posedge sys_clk) disable iff (!rst_b)
        $rose(wdt_sys_reset));
    c_irq: cover property (@(posedge sys_clk) disable iff (!rst_b)
        $rose(wdt_irq));
    c_debug_block: cover property (@(posedge sys_clk) disable iff (!rst_b)
        core_debug_acknowledge && s_r.ctrl[WDTINT_CTRL_EN_BIT]);
    c_interval: cover property (@(posedge sys_clk) disable iff (!rst_b)
        timeout && !s_r.ctrl[WDTINT_CTRL_RST_EN_BIT]);

endmodule
